// ### design/acsf_pkg.sv
// Contract
// - Start on oscillator, then hand over to the external clock
// - Count clock falling edges; accept at or above 1.15 MHz
// - On failure stay on oscillator, flag the error
// - Fault state outputs no data; only reset exits
// - Low strap selects the single-ended CMOS clock
// - High strap selects the crystal or LVDS clock
// - LVDS is available only in SPI control mode
// - LVDS enable via bit 3, with GPIO input low or GPIO direction bit set
// - Pin mode: reference buffers off; SPI: per-buffer enables
// - Filter per channel in SPI mode, shared in pin mode
// - Sinc5 or wideband low ripple filter type
// - Six selectable decimation rates per filter
// - Wideband group delay about 34 output periods
// - Wideband withholds settled data after a sync
// - Filters resynchronise on a sync rising edge
// - First ready at 336 periods; settled at 336 for sinc5, 8400 for wideband
package acsf_pkg;
  localparam logic [7:0] ADDR_CH_STANDBY = 8'h00;
  localparam logic [7:0] ADDR_PWR_CLK    = 8'h04;
  localparam logic [7:0] ADDR_FILT_TYPE  = 8'h40;
  localparam logic [7:0] ADDR_DECIM      = 8'h41;
  localparam logic [7:0] ADDR_REF_POS    = 8'h42;
  localparam logic [7:0] ADDR_REF_NEG    = 8'h43;
  localparam logic [7:0] ADDR_GPIO_DIR   = 8'h44;
  localparam logic [7:0] ADDR_STATUS     = 8'h45;
  localparam int         PWR_LVDS_BIT    = 3;
  localparam int         STAT_CLKERR_BIT = 0;
  localparam int         STAT_EXT_BIT    = 1;
  localparam int         XTAL_CH         = 4;
  localparam logic [7:0] PWR_RESET       = 8'h00;
  localparam logic [7:0] STANDBY_RESET   = 8'h00;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [2:0] DECIM_RESET     = 3'h0;
  localparam logic [2:0] DECIM_MAX       = 3'h5;
  localparam int         BW_SINC5_MILLI  = 204;
  localparam int         BW_WIDE_MILLI   = 433;
  localparam int         WIDE_GD_ODR     = 34;
  localparam int         OSC_KHZ         = 20000;
  localparam int         MIN_MCLK_KHZ    = 1150;
  localparam int         STARTUP_CYC     = 4;
  localparam int         WIN_CYC         = 400;
  localparam int         MIN_EDGES       = (WIN_CYC * MIN_MCLK_KHZ) / OSC_KHZ;
  localparam int         FIRST_SAMPLE_READY_STROBE_MCLK = 336;
  localparam int         SETTLE_MCLK     = 8400;
  typedef enum logic [1:0] {ST_STARTUP, ST_CHECK, ST_RUN, ST_FAULT} acsf_state_t;
endpackage : acsf_pkg

// ### design/acsf_sync2.sv
`timescale 1ns/1ns
module acsf_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : acsf_sync2

// ### design/acsf_core.sv
`timescale 1ns/1ns
module acsf_core
  import acsf_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_MCLK
) (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       MCLK_IN,
  input  wire logic       CLK_SEL,
  input  wire logic       SPI_MODE,
  input  wire logic       SYNC_IN,
  input  wire logic       LVDS_STRAP_GPIO_LINE,
  input  wire logic       FILT_PIN,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic            CLK_USE_EXT,
  output logic            CLK_ERR,
  output logic            HDR_ERR,
  output logic            DATA_EN,
  output logic            SEL_XTAL_LVDS,
  output logic            LVDS_EN,
  output logic            XTAL_EXC_EN,
  output logic      [7:0] REF_BUF_P_EN,
  output logic      [7:0] REF_BUF_N_EN,
  output logic      [7:0] FILT_WIDEBAND,
  output logic      [2:0] DECIM_SEL,
  output logic            SAMPLE_READY_STROBE,
  output logic            SETTLED
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [4:0] pins_s;
  logic       mclk_s;
  logic       sel_s;
  logic       spi_s;
  logic       sync_s;
  logic       gpio_s;

  acsf_sync2 #(.W(5)) u_sync (
    .clk   (CLK),
    .rst_n (RESETN),
    .din   ({MCLK_IN, CLK_SEL, SPI_MODE, SYNC_IN, LVDS_STRAP_GPIO_LINE}),
    .dout  (pins_s)
  );
  assign {mclk_s, sel_s, spi_s, sync_s, gpio_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Clock validation and handover
  acsf_state_t state_q, state_d;
  logic [8:0]  win_q, win_d;
  logic [8:0]  edges_q, edges_d;
  logic        mclk_prev_q;
  logic        sel_q, sel_d;
  logic        spi_q, spi_d;
  logic        mclk_fall;

  assign mclk_fall = mclk_prev_q & ~mclk_s;

  always_comb begin
    state_d = state_q;
    win_d   = win_q + 9'h001;
    edges_d = edges_q;
    sel_d   = sel_q;
    spi_d   = spi_q;
    unique case (state_q)
      ST_STARTUP: begin
        if (win_q == 9'(STARTUP_CYC - 1)) begin
          sel_d   = sel_s;
          spi_d   = spi_s;
          state_d = ST_CHECK;
          win_d   = 9'h000;
          edges_d = 9'h000;
        end
      end
      ST_CHECK: begin
        if (mclk_fall && edges_q != 9'h1FF) edges_d = edges_q + 9'h001;
        if (win_q == 9'(WIN_CYC - 1)) begin
          state_d = (edges_d >= 9'(MIN_EDGES)) ? ST_RUN : ST_FAULT;
          win_d   = 9'h000;
        end
      end
      ST_RUN: win_d = 9'h000;
      ST_FAULT: win_d = 9'h000;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q     <= ST_STARTUP;
      win_q       <= 9'h000;
      edges_q     <= 9'h000;
      mclk_prev_q <= 1'b0;
      sel_q       <= 1'b0;
      spi_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      win_q       <= win_d;
      edges_q     <= edges_d;
      mclk_prev_q <= mclk_s;
      sel_q       <= sel_d;
      spi_q       <= spi_d;
    end
  end

  assign CLK_USE_EXT   = (state_q == ST_RUN);
  assign CLK_ERR       = (state_q == ST_FAULT);
  assign HDR_ERR       = CLK_ERR;
  assign DATA_EN       = CLK_USE_EXT;
  assign SEL_XTAL_LVDS = sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] stby_q, stby_d;
  logic [7:0] pwr_q, pwr_d;
  logic [7:0] filt_q, filt_d;
  logic [2:0] dec_q, dec_d;
  logic [7:0] refp_q, refp_d;
  logic [7:0] refn_q, refn_d;
  logic       gdir_q, gdir_d;
  logic [7:0] rd_q, rd_d;

  always_comb begin
    stby_d = stby_q;
    pwr_d  = pwr_q;
    filt_d = filt_q;
    dec_d  = dec_q;
    refp_d = refp_q;
    refn_d = refn_q;
    gdir_d = gdir_q;
    rd_d   = rd_q;
    if (REG_WR && spi_q) begin
      unique case (REG_ADDR)
        ADDR_CH_STANDBY: stby_d = REG_WDATA;
        ADDR_PWR_CLK:    pwr_d  = REG_WDATA;
        ADDR_FILT_TYPE:  filt_d = REG_WDATA;
        ADDR_DECIM:      dec_d  = (REG_WDATA[2:0] > DECIM_MAX) ? DECIM_MAX : REG_WDATA[2:0];
        ADDR_REF_POS:    refp_d = REG_WDATA;
        ADDR_REF_NEG:    refn_d = REG_WDATA;
        ADDR_GPIO_DIR:   gdir_d = REG_WDATA[0];
        default: ;
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CH_STANDBY: rd_d = stby_q;
        ADDR_PWR_CLK:    rd_d = pwr_q;
        ADDR_FILT_TYPE:  rd_d = filt_q;
        ADDR_DECIM:      rd_d = {5'h00, dec_q};
        ADDR_REF_POS:    rd_d = refp_q;
        ADDR_REF_NEG:    rd_d = refn_q;
        ADDR_GPIO_DIR:   rd_d = {7'h00, gdir_q};
        ADDR_STATUS:     rd_d = {6'h00, CLK_USE_EXT, CLK_ERR};
        default:         rd_d = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stby_q <= STANDBY_RESET;
      pwr_q  <= PWR_RESET;
      filt_q <= BYTE_ZERO;
      dec_q  <= DECIM_RESET;
      refp_q <= BYTE_ZERO;
      refn_q <= BYTE_ZERO;
      gdir_q <= 1'b0;
      rd_q   <= BYTE_ZERO;
    end else begin
      stby_q <= stby_d;
      pwr_q  <= pwr_d;
      filt_q <= filt_d;
      dec_q  <= dec_d;
      refp_q <= refp_d;
      refn_q <= refn_d;
      gdir_q <= gdir_d;
      rd_q   <= rd_d;
    end
  end

  assign REG_RDATA     = rd_q;
  // LVDS needs SPI mode, high strap, and a legal GPIO setup
  assign LVDS_EN       = spi_q & sel_q & pwr_q[PWR_LVDS_BIT]
                       & (gdir_q | ~gpio_s);
  assign XTAL_EXC_EN   = sel_q & ~LVDS_EN & ~stby_q[XTAL_CH];
  assign REF_BUF_P_EN  = spi_q ? refp_q : BYTE_ZERO;
  assign REF_BUF_N_EN  = spi_q ? refn_q : BYTE_ZERO;
  assign FILT_WIDEBAND = spi_q ? filt_q : {8{FILT_PIN}};
  assign DECIM_SEL     = dec_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sync and settling
  logic        sync_prev_q;
  logic        sync_rise;
  logic        busy_q, busy_d;
  logic [19:0] mcnt_q, mcnt_d;
  logic        rdy_q, rdy_d;
  logic        set_q, set_d;
  logic        any_wide;

  assign sync_rise = sync_s & ~sync_prev_q;
  assign any_wide  = |FILT_WIDEBAND;

  always_comb begin
    busy_d = busy_q;
    mcnt_d = mcnt_q;
    rdy_d  = 1'b0;
    set_d  = set_q;
    if (sync_rise && CLK_USE_EXT) begin
      busy_d = 1'b1;
      mcnt_d = 20'h00000;
      set_d  = 1'b0;
    end else if (busy_q && mclk_fall) begin
      mcnt_d = mcnt_q + 20'h00001;
      if (mcnt_d == 20'(FIRST_SAMPLE_READY_STROBE_MCLK)) begin
        rdy_d = 1'b1;
        if (!any_wide) begin
          set_d  = 1'b1;
          busy_d = 1'b0;
        end
      end
      // Wideband settling covers its long group delay
      if (mcnt_d == 20'(SETTLE_CNT)) begin
        set_d  = 1'b1;
        busy_d = 1'b0;
      end
    end
    if (!CLK_USE_EXT) begin
      busy_d = 1'b0;
      rdy_d  = 1'b0;
      set_d  = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_prev_q <= 1'b0;
      busy_q      <= 1'b0;
      mcnt_q      <= 20'h00000;
      rdy_q       <= 1'b0;
      set_q       <= 1'b0;
    end else begin
      sync_prev_q <= sync_s;
      busy_q      <= busy_d;
      mcnt_q      <= mcnt_d;
      rdy_q       <= rdy_d;
      set_q       <= set_d;
    end
  end

  assign SAMPLE_READY_STROBE = rdy_q;
  assign SETTLED             = set_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_fault_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
    CLK_ERR |=> CLK_ERR && !CLK_USE_EXT) else $error("clock error cleared");
  chk_fault_nodata: assert property (@(posedge CLK) disable iff (!RESETN)
    CLK_ERR |-> !DATA_EN && !SAMPLE_READY_STROBE) else $error("data in fault");
  chk_check_pass: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_CHECK && win_q == 9'(WIN_CYC - 1) && edges_d >= 9'(MIN_EDGES))
    |=> CLK_USE_EXT) else $error("valid clock not taken");
  chk_check_fail: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_CHECK && win_q == 9'(WIN_CYC - 1) && edges_d < 9'(MIN_EDGES))
    |=> CLK_ERR && HDR_ERR && !CLK_USE_EXT) else $error("bad clock not flagged");
  chk_strap_take: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_STARTUP && win_q == 9'(STARTUP_CYC - 1))
    |=> SEL_XTAL_LVDS == $past(sel_s)) else $error("strap not taken");
  chk_lvds_spi: assert property (@(posedge CLK) disable iff (!RESETN)
    LVDS_EN |-> spi_q && SEL_XTAL_LVDS && !XTAL_EXC_EN) else $error("lvds illegal");
  chk_ref_pin: assert property (@(posedge CLK) disable iff (!RESETN)
    !spi_q |-> REF_BUF_P_EN == 8'h00 && REF_BUF_N_EN == 8'h00) else $error("ref buf on");
  chk_filt_pin: assert property (@(posedge CLK) disable iff (!RESETN)
    !spi_q |-> FILT_WIDEBAND == {8{FILT_PIN}}) else $error("filter not shared");
  chk_first_ready: assert property (@(posedge CLK) disable iff (!RESETN)
    SAMPLE_READY_STROBE |-> mcnt_q == 20'(FIRST_SAMPLE_READY_STROBE_MCLK)) else $error("ready early");
  chk_settle_wide: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(SETTLED) && any_wide |-> mcnt_q == 20'(SETTLE_CNT)) else $error("settled early");
endmodule : acsf_core

// ### test/acsf_mclk_model.sv
`timescale 1ns/1ns
module acsf_mclk_model (
  input  wire logic        en,
  input  wire logic [15:0] half_ns,
  output logic             mclk
);
  // Master clock source at the set rate; held low while disabled
  always begin
    if (en) begin
      #(half_ns);
      mclk = ~mclk;
    end else begin
      mclk = 1'h0;
      #50;
    end
  end
endmodule : acsf_mclk_model

// ### test/test_adc_clock_select_filter_cfg.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module test_adc_clock_select_filter_cfg;
  import acsf_pkg::*;
  logic CLK = 1'h0, RESETN = 1'h0, CLK_SEL = 1'h0, SPI_MODE = 1'h1, SYNC_IN = 1'h0;
  logic LVDS_STRAP_GPIO_LINE = 1'h0, FILT_PIN = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, rd;
  logic [7:0] REF_BUF_P_EN, REF_BUF_N_EN, FILT_WIDEBAND, mdl [int];
  logic [2:0] DECIM_SEL;
  logic CLK_USE_EXT, CLK_ERR, HDR_ERR, DATA_EN, SEL_XTAL_LVDS, LVDS_EN, XTAL_EXC_EN;
  logic SAMPLE_READY_STROBE, SETTLED, MCLK_IN, mclk_en = 1'h0, spi, seen;
  logic [15:0] half_ns = 16'h0190;
  int miscompares = 0, checked = 0, mcnt = 0, n;
  acsf_mclk_model mclk_u (.en(mclk_en), .half_ns(half_ns), .mclk(MCLK_IN));
  acsf_core #(.SETTLE_CNT(500)) dut_u (.CLK, .RESETN, .MCLK_IN, .CLK_SEL, .SPI_MODE,
    .SYNC_IN, .LVDS_STRAP_GPIO_LINE, .FILT_PIN, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .CLK_USE_EXT, .CLK_ERR, .HDR_ERR, .DATA_EN, .SEL_XTAL_LVDS, .LVDS_EN,
    .XTAL_EXC_EN, .REF_BUF_P_EN, .REF_BUF_N_EN, .FILT_WIDEBAND, .DECIM_SEL,
    .SAMPLE_READY_STROBE, .SETTLED);
  always #25 CLK = ~CLK;
  always @(negedge MCLK_IN) mcnt++;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ex(input logic [7:0] a);
    return mdl.exists(a) ? mdl[a] : 8'h00;
  endfunction : ex
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_WR = 1'h1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'h0;
    if (spi && a inside {ADDR_CH_STANDBY, ADDR_PWR_CLK, [ADDR_FILT_TYPE:ADDR_GPIO_DIR]})
      mdl[a] = (a == ADDR_DECIM && d > 8'h05) ? 8'h05 : d;
  endtask : wr
  task automatic rdc(input logic [7:0] a);
    @(negedge CLK);
    REG_RD = 1'h1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'h0;
    rd = REG_RDATA;
  endtask : rdc
  task automatic boot(input logic sel, input logic sp, input logic [15:0] h);
    CLK_SEL = sel;
    SPI_MODE = sp;
    spi = sp;
    half_ns = h;
    mclk_en = 1'h1;
    mdl.delete();
    RESETN = 1'h0;
    repeat (3) @(negedge CLK);
    RESETN = 1'h1;
    repeat (420) @(negedge CLK);
  endtask : boot
  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #4000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(43165));
    // CMOS clock at 1.25 MHz, SPI mode
    boot(1'h0, 1'h1, 16'h0190);
    `CHK("use_ext", 1'h1, CLK_USE_EXT)
    `CHK("clk_err", 1'h0, CLK_ERR)
    `CHK("data_en", 1'h1, DATA_EN)
    `CHK("sel", 1'h0, SEL_XTAL_LVDS)
    rdc(ADDR_STATUS);
    `CHK("status", 8'h02, rd)
    // Decimation codes, per-channel filter and buffer enables
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_DECIM, 8'(i));
      wr(ADDR_FILT_TYPE, 8'($urandom));
      wr(ADDR_REF_POS, 8'($urandom));
      wr(ADDR_REF_NEG, 8'($urandom));
      rdc(ADDR_DECIM);
      `CHK("decim", ex(ADDR_DECIM), rd)
      `CHK("decim_sel", 3'(ex(ADDR_DECIM)), DECIM_SEL)
      `CHK("filt", ex(ADDR_FILT_TYPE), FILT_WIDEBAND)
      `CHK("ref_p", ex(ADDR_REF_POS), REF_BUF_P_EN)
      `CHK("ref_n", ex(ADDR_REF_NEG), REF_BUF_N_EN)
    end
    wr(ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS);
    `CHK("status_ro", 8'h02, rd)
    wr(8'h7E, 8'hAA);
    rdc(8'h7E);
    `CHK("unmapped", 8'h00, rd)
    // LVDS bit with the CMOS strap stays off
    wr(ADDR_PWR_CLK, 8'h08);
    rdc(ADDR_PWR_CLK);
    `CHK("pwr", ex(ADDR_PWR_CLK), rd)
    `CHK("cmos_lvds", 1'h0, LVDS_EN)
    // Sync after reconfiguration: wideband then sinc5
    for (int w = 1; w >= 0; w--) begin
      wr(ADDR_FILT_TYPE, 8'(w));
      @(negedge CLK);
      SYNC_IN = 1'h1;
      mcnt = 0;
      repeat (5) @(negedge CLK);
      `CHK("settled_clr", 1'h0, SETTLED)
      for (n = 0; n < 20000 && SAMPLE_READY_STROBE !== 1'h1; n++) @(negedge CLK);
      `CHK("first_ready", 1'h1, 1'(mcnt inside {[334:338]}))
      for (n = 0; n < 20000 && SETTLED !== 1'h1; n++) @(negedge CLK);
      `CHK("settle", 1'h1, 1'(mcnt inside {[(w ? 498 : 334):(w ? 502 : 338)]}))
      SYNC_IN = 1'h0;
    end
    // Crystal or LVDS strap and the two LVDS enable paths
    boot(1'h1, 1'h1, 16'h0190);
    `CHK("sel", 1'h1, SEL_XTAL_LVDS)
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_GPIO_DIR, 8'(k == 2));
      LVDS_STRAP_GPIO_LINE = (k != 0);
      wr(ADDR_PWR_CLK, 8'h08);
      repeat (3) @(negedge CLK);
      `CHK("lvds", 1'(k != 1), LVDS_EN)
      `CHK("xtal", 1'(k == 1), XTAL_EXC_EN)
    end
    wr(ADDR_PWR_CLK, 8'h00);
    wr(ADDR_CH_STANDBY, 8'h10);
    `CHK("xtal_stby", 1'h0, XTAL_EXC_EN)
    // Pin control mode refuses writes
    boot(1'h1, 1'h0, 16'h0190);
    FILT_PIN = 1'h1;
    LVDS_STRAP_GPIO_LINE = 1'h0;
    wr(ADDR_PWR_CLK, 8'h08);
    wr(ADDR_REF_POS, 8'hFF);
    repeat (3) @(negedge CLK);
    `CHK("pin_lvds", 1'h0, LVDS_EN)
    `CHK("pin_ref", 8'h00, REF_BUF_P_EN)
    `CHK("pin_filt", 8'hFF, FILT_WIDEBAND)
    rdc(ADDR_REF_POS);
    `CHK("pin_wr", 8'h00, rd)
    // Clock at 1 MHz is below the limit
    boot(1'h0, 1'h1, 16'h01F4);
    `CHK("err", 1'h1, CLK_ERR)
    `CHK("hdr", 1'h1, HDR_ERR)
    `CHK("no_ext", 1'h0, CLK_USE_EXT)
    `CHK("no_data", 1'h0, DATA_EN)
    rdc(ADDR_STATUS);
    `CHK("status_err", 8'h01, rd)
    SYNC_IN = 1'h1;
    seen = 1'h0;
    repeat (8000) @(negedge CLK) seen |= (SAMPLE_READY_STROBE === 1'h1);
    SYNC_IN = 1'h0;
    `CHK("no_ready", 1'h0, seen)
    `CHK("err_sticky", 1'h1, CLK_ERR)
    boot(1'h0, 1'h1, 16'h0190);
    `CHK("reset_exit", 1'h1, CLK_USE_EXT)
    end_of_test();
  end
endmodule : test_adc_clock_select_filter_cfg
